// ---- rtl/fan_pwm_defines.vh ----
`ifndef FAN_PWM_DEFINES_VH
`define FAN_PWM_DEFINES_VH

`define CLK_HZ            200000000
`define CLK_MHZ           200

// Register indices; byte address is four times the index
`define IDX_SLOPE_FREQ1   10'h05f
`define IDX_SLOPE_FREQ2   10'h060
`define IDX_SLOPE_FREQ3   10'h061
`define IDX_ACOUSTIC1     10'h062
`define IDX_CONFIG        10'h040
`define IDX_AUTO1         10'h041
`define IDX_AUTO2         10'h042
`define IDX_AUTO3         10'h043
`define IDX_STATUS        10'h044

`define SLOPE_PWM_RATE_SELECT_RESET  8'hc4
`define ACOUSTIC_RESET    8'h00
`define CONFIG_RESET      4'h0
`define AUTO_RESET        28'h464405a

// Slope/frequency fields
`define PWM_RATE_SELECT_LSB          0
`define ALARM_EN_BIT      3
`define SLOPE_LSB         4
// Acoustic fields
`define RAMP_LSB          0
`define RAMP_EN_BIT       3
`define SYNC_BIT          4
`define FLOOR_LSB         5
// Config fields
`define LOCK_BIT          0
`define AUTO_EN_LSB       1

// Output frequencies in millihertz, 256 duty steps per period
`define PWM_STEPS         256
`define FREQ0_MHZ         11000
`define FREQ1_MHZ         14700
`define FREQ2_MHZ         22100
`define FREQ3_MHZ         29400
`define FREQ4_MHZ         35300
`define FREQ5_MHZ         44100
`define FREQ6_MHZ         58800
`define FREQ7_MHZ         88200

// Slowest ramp: 33% to 100% (171 steps) in 35 s
`define RAMP_FULL_US      35000000
`define RAMP_SPAN_STEPS   171

// Alarm held for one full monitoring cycle: two cycle boundaries
`define ALARM_HOLD_TICKS  2'd2

`endif

// ---- rtl/fan_pwm_cfg.v ----
// Behaviour
// R01 - Frequency code selects PWM rate, 11.0-88.2 Hz
// R02 - Reset: frequency code 100, slope code 1100
// R03 - Alarm enabled: pull pin when over limit+0.25C
// R04 - Hold alarm until temperature at or below limit
// R05 - Alarm lasts at least one full monitoring cycle
// R06 - Alarm disabled: never drive pin from channel
// R07 - Slope code sets duty-rise temperature span
// R08 - Reserved slope code 1110 uses 40C span
// R09 - Lock makes slope, frequency, acoustic registers read-only
// R10 - Ramp fan one toward new duty by code
// R11 - Acoustic enable bit turns fan one ramp on
// R12 - Sync set: speed inputs 2,3,4 follow fan three
// R13 - Sync clear: only speed inputs 3,4 follow
// R14 - Floor bits pick zero or minimum duty below threshold
// R15 - Channels pair remote1, local, remote2 with fans 1-3
`timescale 1ns/1ps
`include "fan_pwm_defines.vh"

module fan_pwm_cfg #(
    parameter [31:0] step_div_0       = `CLK_HZ / (`FREQ0_MHZ * `PWM_STEPS / 1000),
    // Faster rates scale from the slowest, so one override retimes all eight
    parameter [31:0] step_div_1       = step_div_0 * `FREQ0_MHZ / `FREQ1_MHZ,
    parameter [31:0] step_div_2       = step_div_0 * `FREQ0_MHZ / `FREQ2_MHZ,
    parameter [31:0] step_div_3       = step_div_0 * `FREQ0_MHZ / `FREQ3_MHZ,
    parameter [31:0] step_div_4       = step_div_0 * `FREQ0_MHZ / `FREQ4_MHZ,
    parameter [31:0] step_div_5       = step_div_0 * `FREQ0_MHZ / `FREQ5_MHZ,
    parameter [31:0] step_div_6       = step_div_0 * `FREQ0_MHZ / `FREQ6_MHZ,
    parameter [31:0] step_div_7       = step_div_0 * `FREQ0_MHZ / `FREQ7_MHZ,
    parameter [31:0] ramp_slot_cycles = `RAMP_FULL_US / `RAMP_SPAN_STEPS * `CLK_MHZ
) (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [9:0]  temp_remote1,
    input  wire [9:0]  temp_local,
    input  wire [9:0]  temp_remote2,
    input  wire        monitor_cycle_tick,
    input  wire        thermal_alarm_pin_in,
    output wire        thermal_alarm_pin_out,
    output wire        thermal_alarm_pin_oe,
    output wire        fan_drive_one,
    output wire        fan_drive_two,
    output wire        fan_drive_three,
    output wire        speed_sync_two,
    output wire        speed_sync_three,
    output wire        speed_sync_four
);

    reg  [31:0] prdata_reg;
    reg         pready_reg;
    reg         pslverr_reg;
    reg  [23:0] slope_pwm_rate_select_reg;
    reg  [7:0]  acoustic_reg;
    reg  [3:0]  config_reg;
    reg  [83:0] auto_reg;
    reg  [2:0]  speed_sync_reg;
    reg         alarm_oe_reg;
    reg  [25:0] slot_cnt_reg;
    reg         slot_tick_reg;
    reg  [31:0] rd_val;
    reg         hit;
    wire [29:0] temp_all;
    wire [2:0]  alarm_w;
    wire [2:0]  drive_w;
    wire [23:0] duty_w;
    wire        setup;
    wire        access;
    wire        wr;
    wire        locked;
    wire [9:0]  idx;

    assign temp_all = {temp_remote2, temp_local, temp_remote1}; // R15
    assign setup    = psel & ~penable;
    assign access   = psel & penable & pready_reg;
    assign wr       = access & pwrite & ~pslverr_reg;
    assign locked   = config_reg[`LOCK_BIT];
    assign idx      = paddr[11:2];

    function [31:0] step_div;
        input [2:0] code;
        begin
            case (code) // R01
                3'd0:    step_div = step_div_0;
                3'd1:    step_div = step_div_1;
                3'd2:    step_div = step_div_2;
                3'd3:    step_div = step_div_3;
                3'd4:    step_div = step_div_4;
                3'd5:    step_div = step_div_5;
                3'd6:    step_div = step_div_6;
                default: step_div = step_div_7;
            endcase
        end
    endfunction

    // Duty gain per quarter degree, scaled by 256: 65280 / span_in_quarters
    function [12:0] slope_gain;
        input [3:0] code;
        begin
            case (code) // R07
                4'h0:    slope_gain = 13'd8160;
                4'h1:    slope_gain = 13'd6528;
                4'h2:    slope_gain = 13'd4896;
                4'h3:    slope_gain = 13'd4080;
                4'h4:    slope_gain = 13'd3264;
                4'h5:    slope_gain = 13'd2448;
                4'h6:    slope_gain = 13'd2040;
                4'h7:    slope_gain = 13'd1632;
                4'h8:    slope_gain = 13'd1224;
                4'h9:    slope_gain = 13'd1020;
                4'ha:    slope_gain = 13'd816;
                4'hb:    slope_gain = 13'd612;
                4'hc:    slope_gain = 13'd510;
                4'hd:    slope_gain = 13'd408;
                4'he:    slope_gain = 13'd408; // R08
                default: slope_gain = 13'd204;
            endcase
        end
    endfunction

    function [5:0] ramp_inc;
        input [2:0] code;
        begin
            case (code) // R10
                3'd0:    ramp_inc = 6'd1;
                3'd1:    ramp_inc = 6'd2;
                3'd2:    ramp_inc = 6'd3;
                3'd3:    ramp_inc = 6'd5;
                3'd4:    ramp_inc = 6'd8;
                3'd5:    ramp_inc = 6'd12;
                3'd6:    ramp_inc = 6'd24;
                default: ramp_inc = 6'd48;
            endcase
        end
    endfunction

    always @* begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        case (idx)
            `IDX_SLOPE_FREQ1: rd_val = {24'h00_0000, slope_pwm_rate_select_reg[7:0]};
            `IDX_SLOPE_FREQ2: rd_val = {24'h00_0000, slope_pwm_rate_select_reg[15:8]};
            `IDX_SLOPE_FREQ3: rd_val = {24'h00_0000, slope_pwm_rate_select_reg[23:16]};
            `IDX_ACOUSTIC1:   rd_val = {24'h00_0000, acoustic_reg};
            `IDX_CONFIG:      rd_val = {28'h000_0000, config_reg};
            `IDX_AUTO1:       rd_val = {4'h0, auto_reg[27:0]};
            `IDX_AUTO2:       rd_val = {4'h0, auto_reg[55:28]};
            `IDX_AUTO3:       rd_val = {4'h0, auto_reg[83:56]};
            `IDX_STATUS:      rd_val = {duty_w, 3'b000, locked, thermal_alarm_pin_in, alarm_w};
            default:          hit    = 1'b0;
        endcase
    end

    // Zero-wait slave: answer prepared in setup, ready in the access cycle
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_val;
            pready_reg  <= 1'b1;
            pslverr_reg <= ~hit;
        end else if (access) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            slope_pwm_rate_select_reg <= {3{`SLOPE_PWM_RATE_SELECT_RESET}}; // R02
            acoustic_reg   <= `ACOUSTIC_RESET;
            config_reg     <= `CONFIG_RESET;
            auto_reg       <= {3{`AUTO_RESET}};
        end else if (wr) begin
            case (idx)
                `IDX_SLOPE_FREQ1: if (!locked) slope_pwm_rate_select_reg[7:0]   <= pwdata[7:0]; // R09
                `IDX_SLOPE_FREQ2: if (!locked) slope_pwm_rate_select_reg[15:8]  <= pwdata[7:0]; // R09
                `IDX_SLOPE_FREQ3: if (!locked) slope_pwm_rate_select_reg[23:16] <= pwdata[7:0]; // R09
                `IDX_ACOUSTIC1:   if (!locked) acoustic_reg          <= pwdata[7:0]; // R09
                // Lock is sticky until reset so it cannot be undone by software
                `IDX_CONFIG:      config_reg <= {pwdata[3:1], pwdata[0] | locked};
                `IDX_AUTO1:       auto_reg[27:0]  <= pwdata[27:0];
                `IDX_AUTO2:       auto_reg[55:28] <= pwdata[27:0];
                `IDX_AUTO3:       auto_reg[83:56] <= pwdata[27:0];
                default: ;
            endcase
        end
    end

    // Ramp time-slot divider
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            slot_cnt_reg  <= 26'd0;
            slot_tick_reg <= 1'b0;
        end else if (slot_cnt_reg >= ramp_slot_cycles[25:0] - 26'd1) begin
            slot_cnt_reg  <= 26'd0;
            slot_tick_reg <= 1'b1;
        end else begin
            slot_cnt_reg  <= slot_cnt_reg + 26'd1;
            slot_tick_reg <= 1'b0;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : chan
            wire [7:0]  sf;
            wire [27:0] au;
            wire [9:0]  t;
            wire [9:0]  fan_start_temperature_q;
            wire [9:0]  limit_q;
            wire [9:0]  hyst_q;
            wire [9:0]  low_q;
            wire [9:0]  over;
            wire [22:0] prod;
            wire [15:0] sum;
            wire [7:0]  auto_duty;
            wire [7:0]  floor_duty;
            wire [7:0]  target;
            wire        ramp_on;
            wire [8:0]  up;
            wire [8:0]  down;
            wire        alarm_en;
            wire [31:0] div;
            reg         running_reg;
            reg  [7:0]  duty_reg;
            reg  [16:0] pre_reg;
            reg  [7:0]  step_reg;
            reg         drive_reg;
            reg         alarm_reg;
            reg  [1:0]  hold_reg;

            assign sf        = slope_pwm_rate_select_reg[8*i +: 8];
            assign au        = auto_reg[28*i +: 28];
            assign t         = temp_all[10*i +: 10];
            assign fan_start_temperature_q    = {au[7:0], 2'b00};
            assign limit_q   = {au[23:16], 2'b00};
            assign hyst_q    = {4'h0, au[27:24], 2'b00};
            assign low_q     = (fan_start_temperature_q >= hyst_q) ? fan_start_temperature_q - hyst_q : 10'd0;
            assign over      = (t > fan_start_temperature_q) ? t - fan_start_temperature_q : 10'd0;
            assign prod      = over * slope_gain(sf[`SLOPE_LSB +: 4]); // R07
            assign sum       = {8'h00, au[15:8]} + {1'b0, prod[22:8]};
            assign auto_duty = (sum > 16'd255) ? 8'hff : sum[7:0];
            assign floor_duty = acoustic_reg[`FLOOR_LSB + i] ? au[15:8] : 8'h00; // R14
            assign target    = !config_reg[`AUTO_EN_LSB + i] ? au[15:8] :
                               (running_reg ? auto_duty : floor_duty);
            assign ramp_on   = (i == 0) && acoustic_reg[`RAMP_EN_BIT]; // R11
            assign up        = {1'b0, duty_reg} + {3'b000, ramp_inc(acoustic_reg[`RAMP_LSB +: 3])};
            assign down      = {1'b0, duty_reg} - {3'b000, ramp_inc(acoustic_reg[`RAMP_LSB +: 3])};
            assign alarm_en  = sf[`ALARM_EN_BIT];
            assign div       = step_div(sf[`PWM_RATE_SELECT_LSB +: 3]);

            assign drive_w[i]          = drive_reg;
            assign alarm_w[i]          = alarm_reg;
            assign duty_w[8*i +: 8]    = duty_reg;

            // Hysteresis band keeps the last on/off decision
            always @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    running_reg <= 1'b0;
                end else if (t >= fan_start_temperature_q) begin
                    running_reg <= 1'b1;
                end else if (t < low_q) begin
                    running_reg <= 1'b0; // R14
                end
            end

            always @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    duty_reg <= 8'h00;
                end else if (!ramp_on) begin
                    duty_reg <= target;
                end else if (slot_tick_reg) begin
                    if (duty_reg < target) begin
                        duty_reg <= (up[8] || up[7:0] > target) ? target : up[7:0]; // R10
                    end else if (duty_reg > target) begin
                        duty_reg <= (down[8] || down[7:0] < target) ? target : down[7:0]; // R10
                    end
                end
            end

            // Current step ends at once, without counter wrap, if a faster rate is chosen mid-step
            always @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    pre_reg   <= 17'd0;
                    step_reg  <= 8'h00;
                    drive_reg <= 1'b0;
                end else begin
                    if (pre_reg >= div[16:0] - 17'd1) begin
                        pre_reg  <= 17'd0;
                        step_reg <= step_reg + 8'h01; // R01
                    end else begin
                        pre_reg <= pre_reg + 17'd1;
                    end
                    drive_reg <= (duty_reg == 8'hff) || (step_reg < duty_reg);
                end
            end

            always @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    alarm_reg <= 1'b0;
                    hold_reg  <= 2'd0;
                end else if (!alarm_en) begin
                    alarm_reg <= 1'b0; // R06
                    hold_reg  <= 2'd0;
                end else if (!alarm_reg) begin
                    if (t > limit_q) begin
                        alarm_reg <= 1'b1; // R03
                    end
                    hold_reg <= 2'd0;
                end else begin
                    if (monitor_cycle_tick && hold_reg != `ALARM_HOLD_TICKS) begin
                        hold_reg <= hold_reg + 2'd1; // R05
                    end
                    if (t <= limit_q && hold_reg == `ALARM_HOLD_TICKS) begin
                        alarm_reg <= 1'b0; // R04
                    end
                end
            end
        end
    endgenerate

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            alarm_oe_reg   <= 1'b0;
            speed_sync_reg <= 3'b110;
        end else begin
            alarm_oe_reg   <= |alarm_w; // R03
            speed_sync_reg <= {2'b11, acoustic_reg[`SYNC_BIT]}; // R12 R13
        end
    end

    assign prdata                = prdata_reg;
    assign pready                = pready_reg;
    assign pslverr               = pslverr_reg;
    // Open drain: only ever pulls low
    assign thermal_alarm_pin_out = 1'b0;
    assign thermal_alarm_pin_oe  = alarm_oe_reg;
    assign fan_drive_one         = drive_w[0];
    assign fan_drive_two         = drive_w[1];
    assign fan_drive_three       = drive_w[2];
    assign speed_sync_two        = speed_sync_reg[0];
    assign speed_sync_three      = speed_sync_reg[1];
    assign speed_sync_four       = speed_sync_reg[2];

endmodule

// ---- tb/fan_pwm_cfg_assertions.sv ----
`timescale 1ns/1ps
module fan_pwm_cfg_assertions (
    input wire        ref_clk,
    input wire        rstn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [9:0]  temp_remote1,
    input wire [9:0]  temp_local,
    input wire [9:0]  temp_remote2,
    input wire        monitor_cycle_tick,
    input wire        thermal_alarm_pin_out,
    input wire        thermal_alarm_pin_oe,
    input wire        speed_sync_two,
    input wire        speed_sync_three,
    input wire        speed_sync_four
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire       acc = psel && penable && pready;
    wire [9:0] idx = paddr[11:2];
    wire       mapped = (idx >= 10'h040 && idx <= 10'h044) || (idx >= 10'h05f && idx <= 10'h062);
    // Alarm limit is left at its 100 C default
    wire       hot = temp_remote1 > 10'd400 || temp_local > 10'd400 || temp_remote2 > 10'd400;
    reg        lock_q;
    reg        sync_q;
    reg [1:0]  ticks;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lock_q <= 1'b0;
            sync_q <= 1'b0;
            ticks <= 2'd0;
        end else begin
            if (acc && pwrite && idx == 10'h040 && pwdata[0])
                lock_q <= 1'b1;
            if (acc && pwrite && idx == 10'h062 && !lock_q)
                sync_q <= pwdata[4];
            if (!thermal_alarm_pin_oe)
                ticks <= 2'd0;
            else if (monitor_cycle_tick && ticks != 2'd3)
                ticks <= ticks + 2'd1;
        end
    end
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_decode: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr does not match decode");
    chk_err_read_zero: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    chk_sync_fixed: assert property (speed_sync_three && speed_sync_four)
        else $error("speed inputs three and four not synchronised");
    chk_sync_follows: assert property (!$changed(sync_q) |-> speed_sync_two == sync_q)
        else $error("speed input two sync wrong");
    chk_alarm_cause: assert property ($rose(thermal_alarm_pin_oe) |-> $past(hot, 2))
        else $error("alarm without hot channel");
    chk_alarm_hold: assert property ($fell(thermal_alarm_pin_oe) |-> ticks >= 2'd2)
        else $error("alarm released before full cycle");
    chk_alarm_release: assert property (thermal_alarm_pin_oe && !hot && ticks >= 2'd2 |-> ##[1:3] !thermal_alarm_pin_oe)
        else $error("alarm not released");
    chk_pin_low_only: assert property (thermal_alarm_pin_out == 1'b0)
        else $error("alarm pin driven high");
    cover property (acc && pslverr);
    cover property ($fell(thermal_alarm_pin_oe));
    cover property ($rose(speed_sync_two));
endmodule

// ---- tb/fan_line_model.sv ----
`timescale 1ns/1ps
module fan_line_model (
    input  wire        ref_clk,
    input  wire        fan_drive_one,
    input  wire        alarm_out,
    input  wire        alarm_oe,
    input  wire        ext_pull_low,
    output wire        pin_level,
    output reg  [31:0] period_one
);
    reg [31:0] cnt = 32'h0;
    reg        last = 1'b0;
    // Open-drain line with pull-up, other parties may pull it low
    assign pin_level = (alarm_oe ? alarm_out : 1'b1) & !ext_pull_low;
    // Fan one period, rising edge to rising edge
    always @(posedge ref_clk) begin
        last <= fan_drive_one;
        cnt <= (fan_drive_one && !last) ? 32'd1 : cnt + 32'd1;
        if (fan_drive_one && !last)
            period_one <= cnt;
    end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    reg         ref_clk = 1'b0;
    reg         rstn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg  [9:0]  t1 = 10'h000;
    reg  [9:0]  t2 = 10'h000;
    reg  [9:0]  t3 = 10'h000;
    reg         tick = 1'b0;
    reg         ext_low = 1'b0;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        pin;
    wire        a_out;
    wire        a_oe;
    wire        f1;
    wire        f2;
    wire        f3;
    wire        s2;
    wire        s3;
    wire        s4;
    wire [31:0] period_one;
    integer     bad_count = 0;
    integer     compares = 0;
    integer     cycles = 0;
    integer     k;
    localparam integer base_div = 17;
    integer     pwm_rate_select_tenths [0:7] = '{110, 147, 221, 294, 353, 441, 588, 882};
    reg  [7:0]  v;
    reg  [32:0] notes[$];

    fan_pwm_cfg #(.step_div_0(base_div), .ramp_slot_cycles(8)) dut (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .temp_remote1(t1),
        .temp_local(t2), .temp_remote2(t3), .monitor_cycle_tick(tick), .thermal_alarm_pin_in(pin),
        .thermal_alarm_pin_out(a_out), .thermal_alarm_pin_oe(a_oe), .fan_drive_one(f1), .fan_drive_two(f2),
        .fan_drive_three(f3), .speed_sync_two(s2), .speed_sync_three(s3), .speed_sync_four(s4));
    fan_line_model fans (.ref_clk(ref_clk), .fan_drive_one(f1), .alarm_out(a_out), .alarm_oe(a_oe),
        .ext_pull_low(ext_low), .pin_level(pin), .period_one(period_one));

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task check(input string what, input [32:0] exp, input [32:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("wrong value %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    task check_level(input string what, input exp, input got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("wrong value %s expected %b seen %b", what, exp, got);
            end
        end
    endtask

    // Expected {pslverr, read data}; writes expect zero data
    task apb(input w, input [11:0] a, input [31:0] d, input [32:0] x);
        begin
            notes.push_back(x);
            @(posedge ref_clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge ref_clk);
            penable <= 1'b1;
            @(posedge ref_clk);
            while (pready !== 1'b1)
                @(posedge ref_clk);
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task pulse;
        begin
            @(posedge ref_clk);
            tick <= 1'b1;
            @(posedge ref_clk);
            tick <= 1'b0;
            repeat (4) @(negedge ref_clk);
        end
    endtask

    task give_verdict;
        begin
            $display("compares %0d bad_count %0d", compares, bad_count);
            if (bad_count == 0 && compares > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1)
            check("apb", notes.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
    end

    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            bad_count = bad_count + 1;
            give_verdict;
        end
    end

    initial begin
        k = $urandom(32'h442e);
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        for (k = 0; k < 3; k = k + 1)
            apb(1'b0, 12'h17c + 12'(4 * k), 32'h0, 33'h0c4);
        apb(1'b0, 12'h188, 32'h0, 33'h0);
        apb(1'b0, 12'h200, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h1fc, 32'h5, {1'b1, 32'h0});
        for (k = 0; k < 6; k = k + 1) begin
            v = 8'($urandom);
            if (k == 5)
                v[7:4] = 4'he;
            apb(1'b1, 12'h180 + 12'(4 * (k % 2)), {24'h0, v}, 33'h0);
            apb(1'b0, 12'h180 + 12'(4 * (k % 2)), 32'h0, {25'h0, v});
        end
        for (k = 0; k < 8; k = k + 1) begin
            apb(1'b1, 12'h17c, {24'h0, 5'h18, 3'(k)}, 33'h0);
            repeat (768 * (base_div * 110 / pwm_rate_select_tenths[k])) @(negedge ref_clk);
            check("period", 33'(256 * (base_div * 110 / pwm_rate_select_tenths[k])), {1'b0, period_one});
        end
        apb(1'b1, 12'h188, 32'h10, 33'h0);
        repeat (3) @(negedge ref_clk);
        check_level("sync two", 1'b1, s2);
        apb(1'b1, 12'h188, 32'h0, 33'h0);
        repeat (3) @(negedge ref_clk);
        check_level("sync two", 1'b0, s2);
        // Auto mode with all channels cold: floor duty per channel
        apb(1'b1, 12'h100, 32'he, 33'h0);
        for (k = 0; k < 3; k = k + 1) begin
            v = k == 0 ? 8'h00 : (k == 1 ? 8'he0 : 8'ha0);
            ext_low <= k == 2;
            apb(1'b1, 12'h188, {24'h0, v}, 33'h0);
            apb(1'b0, 12'h110, 32'h0, {1'b0, v[7] ? 8'h40 : 8'h0, v[6] ? 8'h40 : 8'h0,
                v[5] ? 8'h40 : 8'h0, 4'h0, k != 2, 3'h0});
        end
        ext_low <= 1'b0;
        apb(1'b1, 12'h100, 32'h0, 33'h0);
        t1 <= 10'd401;
        repeat (8) @(negedge ref_clk);
        check_level("alarm oe", 1'b0, a_oe);
        apb(1'b1, 12'h17c, 32'hcc, 33'h0);
        repeat (3) @(negedge ref_clk);
        check_level("alarm oe", 1'b1, a_oe);
        pulse;
        pulse;
        check_level("alarm oe", 1'b1, a_oe);
        @(posedge ref_clk);
        t1 <= 10'd400;
        repeat (3) @(negedge ref_clk);
        check_level("alarm oe", 1'b0, a_oe);
        @(posedge ref_clk);
        t1 <= 10'd401;
        @(posedge ref_clk);
        t1 <= 10'd400;
        repeat (6) @(negedge ref_clk);
        check_level("alarm oe", 1'b1, a_oe);
        pulse;
        check_level("alarm oe", 1'b1, a_oe);
        pulse;
        check_level("alarm oe", 1'b0, a_oe);
        // Ramp on fan one at the slowest code: full duty is reached only gradually
        apb(1'b1, 12'h188, 32'ha8, 33'h0);
        apb(1'b1, 12'h104, 32'h464ff5a, 33'h0);
        repeat (100) @(negedge ref_clk);
        v = 8'h01;
        repeat (1280) begin
            @(negedge ref_clk);
            v[0] = v[0] & f1;
        end
        check_level("ramp partial", 1'b0, v[0]);
        repeat (4400) begin
            @(negedge ref_clk);
            v[1] = v[1] | f2;
            v[2] = v[2] | f3;
        end
        check_level("fan two", 1'b1, v[1]);
        check_level("fan three", 1'b1, v[2]);
        apb(1'b0, 12'h110, 32'h0, {1'b0, 8'h40, 8'h40, 8'hff, 4'h0, 1'b1, 3'h0});
        apb(1'b1, 12'h100, 32'h1, 33'h0);
        apb(1'b1, 12'h17c, 32'h35, 33'h0);
        apb(1'b1, 12'h188, 32'h10, 33'h0);
        apb(1'b1, 12'h100, 32'h0, 33'h0);
        apb(1'b0, 12'h17c, 32'h0, 33'h0cc);
        apb(1'b0, 12'h188, 32'h0, 33'h0a8);
        @(posedge ref_clk);
        check("notes left", 33'h0, 33'(notes.size()));
        give_verdict;
    end
endmodule

bind fan_pwm_cfg fan_pwm_cfg_assertions u_chk (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .temp_remote1, .temp_local, .temp_remote2, .monitor_cycle_tick,
    .thermal_alarm_pin_out, .thermal_alarm_pin_oe, .speed_sync_two, .speed_sync_three, .speed_sync_four);
